// file: verilog/bfs_top.sv
// Balancer fault supervisor: fault gating and communication watchdog
`timescale 1ns/1ps
// Function
// - Any cell overvoltage stops all balancers
// - Comparator outputs qualified by steady time
// - Command kept and resumed after overvoltage
// - Gate drive check per balancer, boost case
// - Low rail resets to no balancing
// - Overtemperature stops balancing, command kept
// - Status readable during thermal shutdown
// - Resume previous command when temperature clears
// - Watchdog starts when command begins executing
// - Valid command byte clears watchdog count
// - Partial transfer counts once byte arrived
// - Flag pin low only while balancing
// - Timeout after 1.5 s releases flag pin
// - Timed out holds balancers, keeps command
// - After timeout only execute or the defeat strap restarts balancers
// - Defeated clamp disables watchdog
// - Valid byte needs matching strapped address
module bfs_top #(
    parameter int WD_TIMEOUT_CYC = bfs_pkg::WD_TIMEOUT_CYC,
    parameter int QUAL_CYC = bfs_pkg::QUAL_CYC
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [5:0] cell_ov_raw_in,
    input wire logic [6:0] gate_ok_raw_in,
    input wire logic boost_sel_in,
    input wire logic overtemp_raw_in,
    input wire logic regulated_rail_low_in,
    input wire logic [4:0] addr_strap_in,
    input wire logic secondary_ontime_set_defeat_in,
    input wire logic cmd_byte_stb_in,
    input wire logic [7:0] cmd_byte_in,
    input wire logic [11:0] hold_cmd_in,
    input wire logic watchdog_flag_pin_in,
    output logic watchdog_flag_pin_out,
    output logic watchdog_flag_pin_oe_out,
    output logic [5:0] bal_en_out,
    output logic [11:0] exec_cmd_out,
    output logic [5:0] ov_flag_out,
    output logic [5:0] gate_ok_out,
    output logic overtemp_out,
    output logic wd_expired_out,
    output logic por_out,
    output logic parity_err_out
);
    // ==========================================
    // Declarations
    logic [bfs_pkg::FI_W-1:0] raw_vec;
    logic [bfs_pkg::FI_W-1:0] filt_vec;
    logic [5:0] ov_f;
    logic [6:0] gate_f;
    logic ot_f;
    logic por_f;
    logic [4:0] addr_f;
    logic pin_high_f;
    logic ov_any;
    logic addr_match;
    logic parity_ok;
    logic byte_valid;
    logic exec_req;
    logic [1:0] op;
    logic balancing;
    logic fault_any;
    logic [5:0] drive_ok;
    logic [5:0] bal_en_nxt;
    logic [11:0] exec_cmd_r;
    logic [5:0] bal_en_r;
    logic [5:0] ov_flag_r;
    logic [5:0] gate_ok_r;
    logic overtemp_r;
    logic wd_expired_r;
    logic por_r;
    logic parity_err_r;
    logic pin_drive_r;
    logic [1:0] strap_raw;
    logic [1:0] strap_sync;
    logic boost_s;
    logic defeat_s;

    bfs_wd_if wd_if ();

    // ==========================================
    // Strap synchronisers
    assign strap_raw = {secondary_ontime_set_defeat_in, boost_sel_in};

    genvar k;
    generate
        for (k = 0; k < 2; k++) begin : g_strap
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic out_r;
            always_ff @(posedge ref_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                end else begin
                    s1_r <= strap_raw[k];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end
            always_ff @(posedge ref_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    out_r <= 1'b0;
                end else if (s2_r == s3_r) begin
                    out_r <= s3_r;
                end
            end
            assign strap_sync[k] = out_r;
        end
    endgenerate

    assign boost_s = strap_sync[0];
    assign defeat_s = strap_sync[1];

    // ==========================================
    // Pin qualification
    assign raw_vec = {
        watchdog_flag_pin_in,
        addr_strap_in,
        regulated_rail_low_in,
        overtemp_raw_in,
        gate_ok_raw_in,
        cell_ov_raw_in
    };

    bfs_qual_filter #(
        .W(bfs_pkg::FI_W),
        .QUAL(QUAL_CYC)
    ) u_filt (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .raw_in(raw_vec),
        .filt_out(filt_vec)
    );

    assign ov_f = filt_vec[bfs_pkg::FI_OV +: 6];
    assign gate_f = filt_vec[bfs_pkg::FI_GATE +: 7];
    assign ot_f = filt_vec[bfs_pkg::FI_OT];
    assign por_f = filt_vec[bfs_pkg::FI_POR];
    assign addr_f = filt_vec[bfs_pkg::FI_ADDR +: 5];
    assign pin_high_f = filt_vec[bfs_pkg::FI_PIN];
    assign ov_any = |ov_f;

    // ==========================================
    // Command byte decode
    assign addr_match = (cmd_byte_in[bfs_pkg::ADDR_MSB:bfs_pkg::ADDR_LSB] == addr_f);
    assign parity_ok = ~(^cmd_byte_in);
    assign op = cmd_byte_in[bfs_pkg::OP_MSB:bfs_pkg::OP_LSB];
    assign byte_valid = cmd_byte_stb_in && addr_match && parity_ok;
    assign exec_req = byte_valid && (op == bfs_pkg::OP_EXECUTE);

    // ==========================================
    // Executing command store
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            exec_cmd_r <= bfs_pkg::EXEC_CMD_RST;
        end else if (por_f) begin
            exec_cmd_r <= bfs_pkg::EXEC_CMD_RST;
        end else if (cmd_byte_stb_in && !parity_ok) begin
            exec_cmd_r <= bfs_pkg::EXEC_CMD_RST;
        end else if (exec_req) begin
            exec_cmd_r <= hold_cmd_in;
        end
    end
    // Only rail low and bad parity clear the store; other faults leave it, so balancing resumes later

    assign balancing = |exec_cmd_r;

    // ==========================================
    // Parity error flag
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            parity_err_r <= 1'b0;
        end else if (por_f) begin
            parity_err_r <= 1'b0;
        end else if (cmd_byte_stb_in) begin
            parity_err_r <= !parity_ok;
        end
    end

    // ==========================================
    // Watchdog control
    assign wd_if.start = exec_req && (|hold_cmd_in) && !por_f;
    assign wd_if.kick = byte_valid;
    assign wd_if.halt = !balancing || por_f;
    assign wd_if.defeat = defeat_s;

    bfs_wdog_timer #(
        .TIMEOUT_CYC(WD_TIMEOUT_CYC)
    ) u_wd (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .wd(wd_if.ctl)
    );

    // ==========================================
    // Gate drive check per balancer
    genvar n;
    generate
        for (n = 0; n < bfs_pkg::CELLS; n++) begin : g_drive
            if (n == bfs_pkg::CELLS - 1) begin : g_top
                assign drive_ok[n] = gate_f[n] && (boost_s || gate_f[n+1]);
            end else begin : g_low
                assign drive_ok[n] = gate_f[n] && gate_f[n+1];
            end
        end
    endgenerate

    // ==========================================
    // Balancer enables
    assign fault_any = ov_any || ot_f || por_f || wd_if.expired || pin_high_f;

    generate
        for (n = 0; n < bfs_pkg::CELLS; n++) begin : g_en
            assign bal_en_nxt[n] = (|exec_cmd_r[11-2*n -: 2]) && drive_ok[n] && !fault_any;
        end
    endgenerate

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bal_en_r <= '0;
        end else begin
            bal_en_r <= bal_en_nxt;
        end
    end

    // ==========================================
    // Watchdog flag pin
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_drive_r <= 1'b0;
        end else begin
            pin_drive_r <= wd_if.running && balancing && !por_f;
        end
    end

    // ==========================================
    // Status
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ov_flag_r <= '0;
        end else begin
            ov_flag_r <= ov_f;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gate_ok_r <= '0;
        end else begin
            gate_ok_r <= drive_ok;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            overtemp_r <= 1'b0;
        end else begin
            overtemp_r <= ot_f;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wd_expired_r <= 1'b0;
        end else begin
            wd_expired_r <= wd_if.expired;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            por_r <= 1'b0;
        end else begin
            por_r <= por_f;
        end
    end

    // ==========================================
    // Outputs
    assign watchdog_flag_pin_out = 1'b0;
    assign watchdog_flag_pin_oe_out = pin_drive_r;
    assign bal_en_out = bal_en_r;
    assign exec_cmd_out = exec_cmd_r;
    assign ov_flag_out = ov_flag_r;
    assign gate_ok_out = gate_ok_r;
    assign overtemp_out = overtemp_r;
    assign wd_expired_out = wd_expired_r;
    assign por_out = por_r;
    assign parity_err_out = parity_err_r;
endmodule

// file: verilog/bfs_pkg.sv
// Shared constants for the balancer fault supervisor
package bfs_pkg;
    // ==========================================
    // Sizes and timing
    localparam int CELLS = 6;
    localparam int CLK_MHZ = 50;
    localparam int QUAL_MIN_NS = 3000;
    localparam int QUAL_CYC = (QUAL_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int WD_TIMEOUT_MS = 1500;
    localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_MS * CLK_MHZ * 1000;
    // ==========================================
    // Command byte layout
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 3;
    localparam int OP_MSB = 2;
    localparam int OP_LSB = 1;
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READBACK = 2'h1;
    localparam logic [1:0] OP_STATUS = 2'h2;
    localparam logic [1:0] OP_EXECUTE = 2'h3;
    localparam logic [11:0] EXEC_CMD_RST = 12'h000;
    // ==========================================
    // Filtered input vector layout
    localparam int FI_OV = 0;
    localparam int FI_GATE = 6;
    localparam int FI_OT = 13;
    localparam int FI_POR = 14;
    localparam int FI_ADDR = 15;
    localparam int FI_PIN = 20;
    localparam int FI_W = 21;
    // ==========================================
    // Watchdog states
    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_RUN = 2'b01,
        WD_EXPIRED = 2'b10
    } bfs_wd_state_t;
endpackage

// file: verilog/bfs_wd_if.sv
// Control and status link between supervisor and watchdog timer
`timescale 1ns/1ps
interface bfs_wd_if;
    logic start;
    logic kick;
    logic halt;
    logic defeat;
    logic expired;
    logic running;
    modport ctl (
        output start,
        output kick,
        output halt,
        output defeat,
        input expired,
        input running
    );
    modport tmr (
        input start,
        input kick,
        input halt,
        input defeat,
        output expired,
        output running
    );
endinterface

// file: verilog/bfs_qual_filter.sv
// Pin synchroniser with stability qualification per bit
`timescale 1ns/1ps
module bfs_qual_filter #(
    parameter int W = 1,
    parameter int QUAL = 150
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [W-1:0] raw_in,
    output logic [W-1:0] filt_out
);
    localparam int CW = $clog2(QUAL + 1);
    localparam logic [CW-1:0] CNT_END = CW'(QUAL - 1);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic out_r;
            logic [CW-1:0] cnt_r;
            // ==========================================
            // Three-stage synchroniser
            always_ff @(posedge ref_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                end else begin
                    s1_r <= raw_in[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end
            // ==========================================
            // Change only after a steady qualification time
            always_ff @(posedge ref_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    cnt_r <= '0;
                    out_r <= 1'b0;
                end else if (s2_r == s3_r && s3_r != out_r) begin
                    if (cnt_r == CNT_END) begin
                        cnt_r <= '0;
                        out_r <= s3_r;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end else begin
                    cnt_r <= '0;
                end
            end
            assign filt_out[i] = out_r;
        end
    endgenerate
endmodule

// file: verilog/bfs_wdog_timer.sv
// Communication watchdog timer
`timescale 1ns/1ps
module bfs_wdog_timer #(
    parameter int TIMEOUT_CYC = 75000000
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    bfs_wd_if.tmr wd
);
    localparam int CW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [CW-1:0] CNT_END = CW'(TIMEOUT_CYC - 1);

    bfs_pkg::bfs_wd_state_t state_r;
    logic [CW-1:0] cnt_r;

    // ==========================================
    // State
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= bfs_pkg::WD_IDLE;
        end else if (wd.defeat) begin
            state_r <= bfs_pkg::WD_IDLE;
        end else if (wd.start) begin
            state_r <= bfs_pkg::WD_RUN;
        end else begin
            case (state_r)
                bfs_pkg::WD_RUN: begin
                    if (wd.halt) begin
                        state_r <= bfs_pkg::WD_IDLE;
                    end else if (!wd.kick && cnt_r == CNT_END) begin
                        state_r <= bfs_pkg::WD_EXPIRED;
                    end
                end
                bfs_pkg::WD_EXPIRED: begin
                    if (wd.halt) begin
                        state_r <= bfs_pkg::WD_IDLE;
                    end
                end
                default: begin
                    state_r <= bfs_pkg::WD_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Count of cycles since the last valid byte
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_r <= '0;
        end else if (wd.kick || wd.start || state_r != bfs_pkg::WD_RUN) begin
            cnt_r <= '0;
        end else if (cnt_r != CNT_END) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign wd.expired = (state_r == bfs_pkg::WD_EXPIRED);
    assign wd.running = (state_r == bfs_pkg::WD_RUN);
endmodule

// file: tb/bfs_top_asserts.sv
// Concurrent checks on the supervisor's ports
`timescale 1ns/1ps
module bfs_top_asserts #(
    parameter int WD_TIMEOUT_CYC = bfs_pkg::WD_TIMEOUT_CYC
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [4:0] addr_strap_in,
    input wire logic secondary_ontime_set_defeat_in,
    input wire logic cmd_byte_stb_in,
    input wire logic [7:0] cmd_byte_in,
    input wire logic [11:0] hold_cmd_in,
    input wire logic watchdog_flag_pin_oe_out,
    input wire logic [5:0] bal_en_out,
    input wire logic [11:0] exec_cmd_out,
    input wire logic [5:0] ov_flag_out,
    input wire logic [5:0] gate_ok_out,
    input wire logic overtemp_out,
    input wire logic wd_expired_out,
    input wire logic por_out
);
    // ==========================================
    // Helpers
    logic ok_byte;
    logic [31:0] idle_cnt_r;
    logic [3:0] dft_hi_r;
    logic [3:0] dft_lo_r;
    function automatic logic [5:0] nz(input logic [11:0] c);
        for (int i = 0; i < 6; i++) nz[i] = |c[11-2*i -: 2];
    endfunction
    assign ok_byte = cmd_byte_stb_in && cmd_byte_in[7:3] == addr_strap_in && !(^cmd_byte_in);
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) idle_cnt_r <= 32'h0;
        else if (ok_byte || !watchdog_flag_pin_oe_out) idle_cnt_r <= 32'h0;
        else idle_cnt_r <= idle_cnt_r + 32'h1;
    end
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dft_hi_r <= 4'h0;
            dft_lo_r <= 4'h0;
        end else begin
            dft_hi_r <= secondary_ontime_set_defeat_in ? dft_hi_r + {3'h0, dft_hi_r != 4'hf} : 4'h0;
            dft_lo_r <= secondary_ontime_set_defeat_in ? 4'h0 : dft_lo_r + {3'h0, dft_lo_r != 4'hf};
        end
    end
    // ==========================================
    // Properties
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    property p_ov; (|ov_flag_out) && $past(|ov_flag_out) |-> bal_en_out == 6'h00; endproperty
    a_ov: assert property (p_ov) else $error("balancer on during overvoltage");
    property p_ot; overtemp_out && $past(overtemp_out) && !$past(cmd_byte_stb_in)
        |-> bal_en_out == 6'h00 && exec_cmd_out == $past(exec_cmd_out); endproperty
    a_ot: assert property (p_ot) else $error("overtemperature gating wrong");
    property p_por; por_out |=> exec_cmd_out == 12'h000 && bal_en_out == 6'h00; endproperty
    a_por: assert property (p_por) else $error("rail low did not clear");
    property p_wd; wd_expired_out && $past(wd_expired_out) |-> bal_en_out == 6'h00 && !watchdog_flag_pin_oe_out;
    endproperty
    a_wd: assert property (p_wd) else $error("timed out but still active");
    property p_keep; $rose(wd_expired_out) |-> exec_cmd_out == $past(exec_cmd_out, 2); endproperty
    a_keep: assert property (p_keep) else $error("command lost on timeout");
    property p_run; (bal_en_out & ~$past(nz(exec_cmd_out))) == 6'h00; endproperty
    a_run: assert property (p_run) else $error("balancer on without command");
    property p_gate; (bal_en_out & ~gate_ok_out & ~$past(gate_ok_out)) == 6'h00; endproperty
    a_gate: assert property (p_gate) else $error("balancer on without gate drive");
    property p_addr; cmd_byte_stb_in && cmd_byte_in[7:3] != addr_strap_in && !(^cmd_byte_in) && !por_out
        |=> exec_cmd_out == $past(exec_cmd_out); endproperty
    a_addr: assert property (p_addr) else $error("foreign byte changed command");
    property p_exec; ok_byte && cmd_byte_in[2:1] == bfs_pkg::OP_EXECUTE && !por_out && dft_lo_r >= 4'h8
        |=> exec_cmd_out == $past(hold_cmd_in)
        ##1 watchdog_flag_pin_oe_out == ($past(hold_cmd_in, 2) != 12'h000); endproperty
    a_exec: assert property (p_exec) else $error("execute not taken");
    property p_def; dft_hi_r >= 4'h7 |-> !watchdog_flag_pin_oe_out && !wd_expired_out; endproperty
    a_def: assert property (p_def) else $error("watchdog active while defeated");
    property p_cnt; watchdog_flag_pin_oe_out |-> idle_cnt_r <= WD_TIMEOUT_CYC + 3; endproperty
    a_cnt: assert property (p_cnt) else $error("timeout late");
    property p_oe; watchdog_flag_pin_oe_out |-> exec_cmd_out != 12'h000 || $past(exec_cmd_out) != 12'h000;
    endproperty
    a_oe: assert property (p_oe) else $error("flag pin pulled without command");
endmodule

// file: tb/bfs_host_model.sv
// Host controller model issuing command bytes
`timescale 1ns/1ps
module bfs_host_model (
    input wire logic ref_clk_in,
    output logic stb_out,
    output logic [7:0] byte_out,
    output logic [11:0] hold_out
);
    initial begin
        stb_out = 1'b0;
        byte_out = 8'h00;
        hold_out = 12'h000;
    end
    // Strobe once the first eight bits are in
    task automatic send(input logic [4:0] a, input logic [1:0] op, input logic [11:0] h, input bit bad);
        @(negedge ref_clk_in);
        stb_out = 1'b1;
        byte_out = {a, op, ^{a, op} ^ bad};
        hold_out = h;
        @(negedge ref_clk_in);
        stb_out = 1'b0;
        byte_out = ~byte_out;
        hold_out = ~h;
    endtask
endmodule

// file: tb/testbench.sv
// Self-checking testbench for the balancer fault supervisor
`timescale 1ns/1ps
module testbench;
    localparam int WD = 60;
    localparam logic [4:0] AD = 5'h0b;
    localparam logic [11:0] HC = 12'hc01;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [5:0] ov = 6'h00;
    logic [6:0] gate = 7'h7f;
    logic boost = 1'b0;
    logic ot = 1'b0;
    logic rail = 1'b0;
    logic dft = 1'b0;
    logic pin_hi = 1'b0;
    logic stb;
    logic [7:0] cb;
    logic [11:0] hold;
    logic oe;
    logic wdx;
    logic oto;
    logic poro;
    logic perr;
    logic [5:0] en;
    logic [5:0] ovf;
    logic [11:0] ex;
    logic [5:0] gok;
    logic pin_o;
    int err_total = 0;
    int n_tests = 0;
    always #10 ref_clk_in = ~ref_clk_in;
    // ==========================================
    // Design and host
    bfs_host_model i_bfs_host_model (.ref_clk_in(ref_clk_in), .stb_out(stb), .byte_out(cb), .hold_out(hold));
    // Pin: weak pull-down, external gate may force it high
    bfs_top #(.WD_TIMEOUT_CYC(WD), .QUAL_CYC(4)) i_bfs_top (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .cell_ov_raw_in(ov), .gate_ok_raw_in(gate), .boost_sel_in(boost), .overtemp_raw_in(ot),
        .regulated_rail_low_in(rail), .addr_strap_in(AD), .secondary_ontime_set_defeat_in(dft),
        .cmd_byte_stb_in(stb), .cmd_byte_in(cb), .hold_cmd_in(hold), .watchdog_flag_pin_in(pin_hi),
        .watchdog_flag_pin_out(pin_o), .watchdog_flag_pin_oe_out(oe), .bal_en_out(en), .exec_cmd_out(ex),
        .ov_flag_out(ovf), .gate_ok_out(gok), .overtemp_out(oto), .wd_expired_out(wdx), .por_out(poro),
        .parity_err_out(perr));
    // ==========================================
    // Shared tasks
    task automatic chk(input bit ok);
        n_tests++;
        if (!ok) begin
            err_total++;
            $display("ERROR %0t: output mismatch", $time);
        end
    endtask
    task automatic summarize;
        $display("Counts: %0d errors, %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task automatic tx(input logic [1:0] op);
        i_bfs_host_model.send(AD, op, HC, 1'b0);
    endtask
    // ==========================================
    // Scenarios
    task automatic s_fault;
        ov = 6'h04;
        cyc(2);
        ov = 6'h00;
        cyc(10);
        chk(ovf === 6'h00 && en === 6'h21);
        tx(bfs_pkg::OP_READBACK);
        ov = 6'h04;
        cyc(12);
        chk(ovf === 6'h04 && en === 6'h00 && ex === HC);
        ov = 6'h00;
        cyc(12);
        chk(en === 6'h21);
        tx(bfs_pkg::OP_STATUS);
        ot = 1'b1;
        cyc(12);
        chk(oto === 1'b1 && en === 6'h00);
        tx(bfs_pkg::OP_STATUS);
        chk(ex === HC);
        ot = 1'b0;
        cyc(12);
        chk(en === 6'h21);
    endtask
    task automatic s_gate;
        tx(bfs_pkg::OP_WRITE);
        gate = 7'h7d;
        cyc(12);
        chk(en === 6'h20 && gok === 6'h3c);
        gate = 7'h3f;
        boost = 1'b1;
        cyc(12);
        chk(en === 6'h21);
        boost = 1'b0;
        cyc(6);
        chk(en === 6'h01);
        gate = 7'h7f;
        cyc(12);
        tx(bfs_pkg::OP_READBACK);
        pin_hi = 1'b1;
        cyc(12);
        chk(en === 6'h00 && ex === HC);
        pin_hi = 1'b0;
        cyc(12);
        chk(en === 6'h21);
    endtask
    task automatic s_wd;
        int n;
        tx(bfs_pkg::OP_STATUS);
        i_bfs_host_model.send(5'h1f, bfs_pkg::OP_STATUS, HC, 1'b0);
        n = 2;
        while (wdx !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        chk(n >= WD && n <= WD + 3);
        if (n >= 100) summarize();
        chk(en === 6'h00 && oe === 1'b0 && ex === HC);
        tx(bfs_pkg::OP_READBACK);
        cyc(3);
        chk(en === 6'h00 && wdx === 1'b1);
        tx(bfs_pkg::OP_EXECUTE);
        cyc(2);
        chk(en === 6'h21 && oe === 1'b1 && wdx === 1'b0);
        for (int i = 0; i < 3; i++) begin
            cyc(40);
            tx(2'(i));
        end
        chk(wdx === 1'b0 && oe === 1'b1);
    endtask
    task automatic s_end;
        i_bfs_host_model.send(5'h1f, bfs_pkg::OP_STATUS, HC, 1'b1);
        cyc(2);
        chk(ex === 12'h000 && en === 6'h00 && perr === 1'b1 && oe === 1'b0);
        dft = 1'b1;
        cyc(6);
        tx(bfs_pkg::OP_EXECUTE);
        cyc(WD + 10);
        chk(en === 6'h21 && oe === 1'b0 && wdx === 1'b0);
        dft = 1'b0;
        rail = 1'b1;
        cyc(12);
        chk(poro === 1'b1 && ex === 12'h000 && en === 6'h00);
        rail = 1'b0;
        cyc(12);
        chk(en === 6'h00 && oe === 1'b0);
    endtask
    initial begin
        cyc(5);
        chk(en === 6'h00 && oe === 1'b0 && ex === 12'h000);
        nrst_in = 1'b1;
        cyc(20);
        tx(bfs_pkg::OP_EXECUTE);
        cyc(2);
        chk(ex === HC && en === 6'h21 && oe === 1'b1 && pin_o === 1'b0);
        s_fault();
        s_gate();
        s_wd();
        s_end();
        summarize();
    end
endmodule
bind bfs_top bfs_top_asserts #(.WD_TIMEOUT_CYC(WD_TIMEOUT_CYC)) i_bfs_top_asserts (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .addr_strap_in(addr_strap_in),
    .secondary_ontime_set_defeat_in(secondary_ontime_set_defeat_in),
    .cmd_byte_stb_in(cmd_byte_stb_in),
    .cmd_byte_in(cmd_byte_in),
    .hold_cmd_in(hold_cmd_in),
    .watchdog_flag_pin_oe_out(watchdog_flag_pin_oe_out),
    .bal_en_out(bal_en_out),
    .exec_cmd_out(exec_cmd_out),
    .ov_flag_out(ov_flag_out),
    .gate_ok_out(gate_ok_out),
    .overtemp_out(overtemp_out),
    .wd_expired_out(wd_expired_out),
    .por_out(por_out)
);
